/* src/simd_dp_pkg.sv */
`default_nettype none
package simd_dp_pkg;
    // operation codes presented by issue logic
    typedef enum logic [4:0] {
        OP_NOP,
        OP_ALIGNED_MOVE_128,
        OP_UNALIGNED_MOVE_128,
        OP_QUAD_LANE_ADD,
        OP_QUAD_LANE_SUBTRACT,
        OP_UNSIGNED_DWORD_MULTIPLY,
        OP_LOW_WORD_SHUFFLE,
        OP_HIGH_WORD_SHUFFLE,
        OP_DWORD_SHUFFLE,
        OP_BYTE_SHIFT_LEFT_128,
        OP_BYTE_SHIFT_RIGHT_128,
        OP_HIGH_QUAD_UNPACK,
        OP_LOW_QUAD_UNPACK,
        OP_MEDIA_TO_VECTOR_MOVE,
        OP_VECTOR_TO_MEDIA_MOVE,
        OP_BYTE_LANE_ADD,
        OP_BYTE_LANE_SUBTRACT
    } op_e;

    localparam int unsigned VEC_W      = 128;
    localparam int unsigned MEDIA_W    = 64;
    localparam int unsigned QUAD_W     = 64;
    localparam int unsigned DWORD_W    = 32;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned IMM_W      = 8;
    localparam int unsigned ADDR_W     = 64;
    localparam int unsigned ALIGN_BITS = 4;    // 16-byte boundary
    localparam int unsigned SEL_W      = 2;    // immediate field per element
    localparam int unsigned MAX_SHIFT  = 15;   // last byte count that keeps data
    localparam int unsigned BYTES_WIDE = 16;
    localparam int unsigned BYTES_NARROW = 8;
    localparam logic [VEC_W-1:0] RES_RESET = '0;
endpackage
`default_nettype wire

/* src/lane_adder.sv */
`default_nettype none
// one lane of a packed add or subtract; carries never cross lanes
module lane_adder
    import simd_dp_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    input  wire logic         i_sub,
    output logic      [W-1:0] o_sum
);
    // wraparound sum is correct for both signed and unsigned readings
    assign o_sum = i_sub ? (i_a - i_b) : (i_a + i_b);
endmodule
`default_nettype wire

/* src/simd_integer_datapath_128.sv */
`default_nettype none
// Summary of operation
// - aligned move faults on memory address not 16-byte aligned; register form never faults
// - unaligned move does the same transfer and never faults on alignment
// - wide form uses 128-bit vector operands, narrow form 64-bit media operands
// - quadword add sums 64-bit lanes, two wide, one narrow, modular
// - quadword subtract differences 64-bit lanes, wide or narrow, modular
// - narrow multiply: low 32-bit elements unsigned, full 64-bit product
// - wide multiply: elements 0 and 2, products to low and high halves
// - low-word shuffle reorders low four words under immediate
// - high-word shuffle reorders high four words under immediate
// - dword shuffle fills four dwords from source under immediate
// - left byte shift moves toward top, zero fill low bytes
// - right byte shift moves toward bottom, zero fill high bytes
// - high unpack interleaves upper halves of destination and source
// - low unpack interleaves lower halves of destination and source
// - media-to-vector move copies 64-bit media value into vector register
// - vector-to-media move copies low 64 bits into media register
// - older packed ops get 128-bit forms doubling lanes, e.g. 16 byte lanes
module simd_integer_datapath_128
    import simd_dp_pkg::*;
(
    input  wire logic               I_CLOCK,
    input  wire logic               I_SYS_RST,
    input  wire logic               I_VALID,
    input  wire logic [4:0]         I_OP,
    input  wire logic               I_WIDE,
    input  wire logic               I_MEM,
    input  wire logic [ADDR_W-1:0]  I_ADDR,
    input  wire logic [VEC_W-1:0]   I_DST,
    input  wire logic [VEC_W-1:0]   I_SRC,
    input  wire logic [IMM_W-1:0]   I_IMM,
    output logic                    O_VALID,
    output logic                    O_GP_FAULT,
    output logic                    O_WIDE,
    output logic [VEC_W-1:0]        O_RESULT
);
    // ----------------------------------------------------------------
    // operand shaping
    // ----------------------------------------------------------------
    op_e              op;
    logic [VEC_W-1:0] a;
    logic [VEC_W-1:0] b;
    logic             misaligned;

    assign op = op_e'(I_OP);
    // narrow forms only look at the low media-register width
    assign a = I_WIDE ? I_DST : {{(VEC_W-MEDIA_W){1'b0}}, I_DST[MEDIA_W-1:0]};
    assign b = I_WIDE ? I_SRC : {{(VEC_W-MEDIA_W){1'b0}}, I_SRC[MEDIA_W-1:0]};
    assign misaligned = I_MEM && (I_ADDR[ALIGN_BITS-1:0] != '0);

    // ----------------------------------------------------------------
    // packed add and subtract lanes
    // ----------------------------------------------------------------
    logic [VEC_W-1:0] quad_sum;
    logic [VEC_W-1:0] byte_sum;
    logic             is_sub_q;
    logic             is_sub_b;

    assign is_sub_q = (op == OP_QUAD_LANE_SUBTRACT);
    assign is_sub_b = (op == OP_BYTE_LANE_SUBTRACT);

    // quadword lanes; narrow form keeps lane 1 at zero inputs
    for (genvar q = 0; q < VEC_W / QUAD_W; q++) begin : g_quad
        lane_adder #(.W(QUAD_W)) u_quad (
            .i_a   (a[q*QUAD_W +: QUAD_W]),
            .i_b   (b[q*QUAD_W +: QUAD_W]),
            .i_sub (is_sub_q),
            .o_sum (quad_sum[q*QUAD_W +: QUAD_W])
        );
    end

    // byte lanes stand for the doubled older packed operations
    for (genvar n = 0; n < BYTES_WIDE; n++) begin : g_byte
        lane_adder #(.W(BYTE_W)) u_byte (
            .i_a   (a[n*BYTE_W +: BYTE_W]),
            .i_b   (b[n*BYTE_W +: BYTE_W]),
            .i_sub (is_sub_b),
            .o_sum (byte_sum[n*BYTE_W +: BYTE_W])
        );
    end

    // ----------------------------------------------------------------
    // unsigned doubleword multiply
    // ----------------------------------------------------------------
    logic [QUAD_W-1:0] prod_lo;
    logic [QUAD_W-1:0] prod_hi;

    assign prod_lo = QUAD_W'(b[DWORD_W-1:0]) * QUAD_W'(a[DWORD_W-1:0]);
    assign prod_hi = QUAD_W'(b[2*DWORD_W +: DWORD_W]) * QUAD_W'(a[2*DWORD_W +: DWORD_W]);

    // ----------------------------------------------------------------
    // shuffles
    // ----------------------------------------------------------------
    logic [MEDIA_W-1:0] wsh_lo;
    logic [MEDIA_W-1:0] wsh_hi;
    logic [VEC_W-1:0]   dsh;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wsh_lo[i*WORD_W +: WORD_W] =
                I_SRC[32'(I_IMM[i*SEL_W +: SEL_W])*WORD_W +: WORD_W];
            wsh_hi[i*WORD_W +: WORD_W] =
                I_SRC[MEDIA_W + 32'(I_IMM[i*SEL_W +: SEL_W])*WORD_W +: WORD_W];
            dsh[i*DWORD_W +: DWORD_W] =
                I_SRC[32'(I_IMM[i*SEL_W +: SEL_W])*DWORD_W +: DWORD_W];
        end
    end

    // ----------------------------------------------------------------
    // whole-register byte shifts
    // ----------------------------------------------------------------
    logic [VEC_W-1:0] shl;
    logic [VEC_W-1:0] shr;
    logic             over;

    // counts past the last byte would alias in a 4-bit shifter, so force zero
    assign over = (I_IMM > IMM_W'(MAX_SHIFT));
    assign shl  = over ? '0 : (I_SRC << {I_IMM[3:0], 3'b000});
    assign shr  = over ? '0 : (I_SRC >> {I_IMM[3:0], 3'b000});

    // ----------------------------------------------------------------
    // result select
    // ----------------------------------------------------------------
    logic [VEC_W-1:0] res_nxt;
    logic             fault_nxt;
    logic             wide_nxt;

    always_comb begin
        res_nxt   = RES_RESET;
        fault_nxt = 1'b0;
        wide_nxt  = I_WIDE;
        unique case (op)
            OP_ALIGNED_MOVE_128: begin
                fault_nxt = misaligned;
                res_nxt   = misaligned ? RES_RESET : I_SRC;
                wide_nxt  = 1'b1;
            end
            OP_UNALIGNED_MOVE_128: begin
                res_nxt  = I_SRC;
                wide_nxt = 1'b1;
            end
            OP_QUAD_LANE_ADD, OP_QUAD_LANE_SUBTRACT: begin
                res_nxt = quad_sum;
            end
            OP_UNSIGNED_DWORD_MULTIPLY: begin
                res_nxt = I_WIDE ? {prod_hi, prod_lo} : {{QUAD_W{1'b0}}, prod_lo};
            end
            OP_LOW_WORD_SHUFFLE: begin
                res_nxt  = {I_SRC[VEC_W-1:MEDIA_W], wsh_lo};
                wide_nxt = 1'b1;
            end
            OP_HIGH_WORD_SHUFFLE: begin
                res_nxt  = {wsh_hi, I_SRC[MEDIA_W-1:0]};
                wide_nxt = 1'b1;
            end
            OP_DWORD_SHUFFLE: begin
                res_nxt  = dsh;
                wide_nxt = 1'b1;
            end
            OP_BYTE_SHIFT_LEFT_128: begin
                res_nxt  = shl;
                wide_nxt = 1'b1;
            end
            OP_BYTE_SHIFT_RIGHT_128: begin
                res_nxt  = shr;
                wide_nxt = 1'b1;
            end
            OP_HIGH_QUAD_UNPACK: begin
                res_nxt  = {I_SRC[VEC_W-1:MEDIA_W], I_DST[VEC_W-1:MEDIA_W]};
                wide_nxt = 1'b1;
            end
            OP_LOW_QUAD_UNPACK: begin
                res_nxt  = {I_SRC[MEDIA_W-1:0], I_DST[MEDIA_W-1:0]};
                wide_nxt = 1'b1;
            end
            OP_MEDIA_TO_VECTOR_MOVE: begin
                res_nxt  = {{(VEC_W-MEDIA_W){1'b0}}, I_SRC[MEDIA_W-1:0]};
                wide_nxt = 1'b1;
            end
            OP_VECTOR_TO_MEDIA_MOVE: begin
                res_nxt  = {{(VEC_W-MEDIA_W){1'b0}}, I_SRC[MEDIA_W-1:0]};
                wide_nxt = 1'b0;
            end
            OP_BYTE_LANE_ADD, OP_BYTE_LANE_SUBTRACT: begin
                res_nxt = byte_sum;
            end
            default: begin
                res_nxt = RES_RESET;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    // one-cycle latency; fault and result leave together
    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_VALID    <= 1'b0;
            O_GP_FAULT <= 1'b0;
            O_WIDE     <= 1'b0;
            O_RESULT   <= RES_RESET;
        end else begin
            O_VALID    <= I_VALID;
            O_GP_FAULT <= I_VALID && fault_nxt;
            O_WIDE     <= wide_nxt;
            O_RESULT   <= I_VALID ? res_nxt : RES_RESET;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_ALIGN_FAULT: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_ALIGNED_MOVE_128 && I_MEM && I_ADDR[3:0] != 4'h0
        |=> O_GP_FAULT && O_RESULT == '0) else $error("misaligned move not faulted");
    AST_UNALIGN_OK: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_UNALIGNED_MOVE_128
        |=> !O_GP_FAULT && O_RESULT == $past(I_SRC)) else $error("unaligned move wrong");
    AST_QADD: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_QUAD_LANE_ADD && I_WIDE |=>
        O_RESULT[127:64] == 64'($past(I_DST[127:64]) + $past(I_SRC[127:64])))
        else $error("quad add high lane wrong");
    AST_QSUB: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_QUAD_LANE_SUBTRACT && !I_WIDE |=>
        O_RESULT == {64'h0, 64'($past(I_DST[63:0]) - $past(I_SRC[63:0]))})
        else $error("narrow quad subtract wrong");
    AST_MUL_WIDE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_UNSIGNED_DWORD_MULTIPLY && I_WIDE |=>
        O_RESULT[127:64] == 64'($past(I_DST[95:64])) * 64'($past(I_SRC[95:64])))
        else $error("wide multiply high product wrong");
    AST_SHL_ZERO: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && (op == OP_BYTE_SHIFT_LEFT_128 || op == OP_BYTE_SHIFT_RIGHT_128)
        && I_IMM > 8'h0f |=> O_RESULT == '0) else $error("oversized shift not zero");
    AST_SHR_ONE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_BYTE_SHIFT_RIGHT_128 && I_IMM == 8'h01 |=>
        O_RESULT == {8'h00, $past(I_SRC[127:8])}) else $error("right byte shift wrong");
    AST_UNPACK_LO: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_LOW_QUAD_UNPACK |=>
        O_RESULT == {$past(I_SRC[63:0]), $past(I_DST[63:0])}) else $error("low unpack wrong");
    AST_V2M: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        I_VALID && op == OP_VECTOR_TO_MEDIA_MOVE |=> !O_WIDE &&
        O_RESULT[63:0] == $past(I_SRC[63:0])) else $error("vector to media move wrong");

    // ----------------------------------------------------------------
    // request sequences
    // ----------------------------------------------------------------
    // fixed immediates keep the expected values readable; other codes are swept by the bench
    localparam logic [IMM_W-1:0] IMM_REVERSE  = 8'h1b;
    localparam logic [IMM_W-1:0] IMM_ONE_BYTE = 8'h01;

    sequence s_reg_move;
        I_VALID && op == OP_ALIGNED_MOVE_128 && !I_MEM;
    endsequence
    sequence s_mul_narrow;
        I_VALID && op == OP_UNSIGNED_DWORD_MULTIPLY && !I_WIDE;
    endsequence
    sequence s_narrow_add;
        I_VALID && op == OP_QUAD_LANE_ADD && !I_WIDE;
    endsequence
    sequence s_reverse_low;
        I_VALID && op == OP_LOW_WORD_SHUFFLE && I_IMM == IMM_REVERSE;
    endsequence
    sequence s_reverse_high;
        I_VALID && op == OP_HIGH_WORD_SHUFFLE && I_IMM == IMM_REVERSE;
    endsequence
    sequence s_reverse_dword;
        I_VALID && op == OP_DWORD_SHUFFLE && I_IMM == IMM_REVERSE;
    endsequence
    sequence s_shl_one;
        I_VALID && op == OP_BYTE_SHIFT_LEFT_128 && I_IMM == IMM_ONE_BYTE;
    endsequence
    sequence s_unpack_hi;
        I_VALID && op == OP_HIGH_QUAD_UNPACK;
    endsequence
    sequence s_m2v;
        I_VALID && op == OP_MEDIA_TO_VECTOR_MOVE;
    endsequence
    sequence s_byte_add_wide;
        I_VALID && op == OP_BYTE_LANE_ADD && I_WIDE;
    endsequence

    // ----------------------------------------------------------------
    // per-operation checks
    // ----------------------------------------------------------------
    // a fault can only come from a taken aligned move that touched memory
    AST_FAULT_SOURCE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        O_GP_FAULT |-> $past(I_VALID) && $past(op) == OP_ALIGNED_MOVE_128 && $past(I_MEM))
        else $error("fault raised by an operation that cannot fault");
    AST_IDLE_QUIET: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        !I_VALID |=> !O_VALID && !O_GP_FAULT && O_RESULT == RES_RESET)
        else $error("idle cycle left a result or fault");
    AST_REG_MOVE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_reg_move |=> !O_GP_FAULT && O_RESULT == $past(I_SRC))
        else $error("register move faulted or lost data");
    AST_MUL_NARROW: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_mul_narrow |=> O_RESULT == {64'h0, 64'($past(I_DST[31:0])) * 64'($past(I_SRC[31:0]))})
        else $error("narrow multiply wrong");
    AST_QADD_NARROW: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_narrow_add |=> !O_WIDE && O_RESULT == {64'h0, 64'($past(I_DST[63:0]) + $past(I_SRC[63:0]))})
        else $error("narrow quad add wrong");
    AST_WSH_LO: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_reverse_low |=> O_RESULT == {$past(I_SRC[127:64]), $past(I_SRC[15:0]),
        $past(I_SRC[31:16]), $past(I_SRC[47:32]), $past(I_SRC[63:48])}) else $error("low shuffle wrong");
    AST_WSH_HI: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_reverse_high |=> O_RESULT == {$past(I_SRC[79:64]), $past(I_SRC[95:80]),
        $past(I_SRC[111:96]), $past(I_SRC[127:112]), $past(I_SRC[63:0])}) else $error("high shuffle wrong");
    AST_DSH: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_reverse_dword |=> O_RESULT == {$past(I_SRC[31:0]), $past(I_SRC[63:32]),
        $past(I_SRC[95:64]), $past(I_SRC[127:96])}) else $error("dword shuffle wrong");
    AST_SHL_ONE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_shl_one |=> O_RESULT == {$past(I_SRC[119:0]), 8'h00})
        else $error("left byte shift wrong");
    AST_UNPACK_HI: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_unpack_hi |=> O_RESULT == {$past(I_SRC[127:64]), $past(I_DST[127:64])})
        else $error("high unpack wrong");
    AST_M2V: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_m2v |=> O_WIDE && O_RESULT == {64'h0, $past(I_SRC[63:0])})
        else $error("media to vector move wrong");
    AST_BYTE_ADD: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s_byte_add_wide |=> O_RESULT[127:120] == 8'($past(I_DST[127:120]) + $past(I_SRC[127:120])))
        else $error("top byte lane add wrong");
endmodule
`default_nettype wire

/* sim/issue_model.sv */
`default_nettype none
// issue and operand fetch side: one request per cycle, driven from the falling edge
module issue_model
    import simd_dp_pkg::*;
(
    output logic               o_valid,
    output logic [4:0]         o_op,
    output logic               o_wide,
    output logic               o_mem,
    output logic [ADDR_W-1:0]  o_addr,
    output logic [VEC_W-1:0]   o_dst,
    output logic [VEC_W-1:0]   o_src,
    output logic [IMM_W-1:0]   o_imm
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet bus until the first request
    initial begin
        {o_valid, o_op, o_wide, o_mem, o_addr, o_dst, o_src, o_imm} = '0;
    end

    // idle cycles scramble the operand lines so the datapath cannot lean on stale values
    task automatic issue(input logic v, input logic [4:0] op, input logic w, input logic m,
                         input logic [ADDR_W-1:0] a, input logic [VEC_W-1:0] d,
                         input logic [VEC_W-1:0] s, input logic [IMM_W-1:0] imm);
        o_valid = v;
        if (v) begin
            {o_op, o_wide, o_mem, o_addr, o_dst, o_src, o_imm} = {op, w, m, a, d, s, imm};
        end else begin
            {o_op, o_wide, o_mem, o_addr, o_dst, o_src, o_imm} =
                ~{o_op, o_wide, o_mem, o_addr, o_dst, o_src, o_imm};
        end
    endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench
    import simd_dp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic               clk = 1'b0;
    logic               rst;
    wire logic          valid, wide, mem, out_valid, fault, out_wide;
    wire logic [4:0]    op;
    wire logic [63:0]   addr;
    wire logic [127:0]  dst, src, result;
    wire logic [7:0]    imm;
    logic               exp_v, exp_f, exp_w, chk_w;
    logic [127:0]       exp_r;
    int                 failures = 0;
    int                 checks_done = 0;

    always #50 clk = ~clk;

    issue_model issue_model_inst (.o_valid(valid), .o_op(op), .o_wide(wide), .o_mem(mem),
        .o_addr(addr), .o_dst(dst), .o_src(src), .o_imm(imm));
    simd_integer_datapath_128 simd_integer_datapath_128_inst (.I_CLOCK(clk), .I_SYS_RST(rst),
        .I_VALID(valid), .I_OP(op), .I_WIDE(wide), .I_MEM(mem), .I_ADDR(addr), .I_DST(dst),
        .I_SRC(src), .I_IMM(imm), .O_VALID(out_valid), .O_GP_FAULT(fault),
        .O_WIDE(out_wide), .O_RESULT(result));

    // ----------------------------------------
    // reference model: bit 128 is the fault
    // ----------------------------------------
    function automatic logic [128:0] model(int o, bit w, bit m, logic [63:0] a,
                                           logic [127:0] d, logic [127:0] s, logic [7:0] i);
        logic [127:0] r;
        r = '0;
        case (o)
            1: if (m && a[3:0] != 4'h0) return {1'b1, 128'h0}; else r = s;
            2: r = s;
            3, 4: for (int k = 0; k < (w ? 2 : 1); k++) begin
                r[k*64+:64] = (o == 3) ? d[k*64+:64] + s[k*64+:64] : d[k*64+:64] - s[k*64+:64];
            end
            5: for (int k = 0; k < (w ? 2 : 1); k++) begin
                r[k*64+:64] = {32'h0, d[k*64+:32]} * {32'h0, s[k*64+:32]};
            end
            6: begin r = s; for (int k = 0; k < 4; k++) r[k*16+:16] = s[i[2*k+:2]*16+:16]; end
            7: begin
                r = s;
                for (int k = 0; k < 4; k++) r[64+k*16+:16] = s[64+i[2*k+:2]*16+:16];
            end
            8: for (int k = 0; k < 4; k++) r[k*32+:32] = s[i[2*k+:2]*32+:32];
            9: r = (i > 15) ? '0 : s << (i * 8);
            10: r = (i > 15) ? '0 : s >> (i * 8);
            11: r = {s[127:64], d[127:64]};
            12: r = {s[63:0], d[63:0]};
            13, 14: r = {64'h0, s[63:0]};
            15, 16: for (int k = 0; k < (w ? 16 : 8); k++) begin
                r[k*8+:8] = (o == 15) ? d[k*8+:8] + s[k*8+:8] : d[k*8+:8] - s[k*8+:8];
            end
            default: r = '0;
        endcase
        return {1'b0, r};
    endfunction

    function automatic logic [127:0] rnd128();
        return {$urandom(), $urandom(), $urandom(), $urandom()};
    endfunction

    task automatic cmp_bit(string name, logic e, logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic cmp_vec(string name, logic [127:0] e, logic [127:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    // outputs of the request taken one edge ago, looked at a half cycle later
    task automatic check_out();
        cmp_bit("valid", exp_v, out_valid);
        cmp_bit("fault", exp_f, fault);
        if (chk_w) cmp_bit("wide", exp_w, out_wide);
        cmp_vec("result", exp_r, result);
    endtask

    // one cycle: judge the previous request, then present the next one
    task automatic step(bit v, int o, bit w, bit m, logic [63:0] a, logic [127:0] d,
                        logic [127:0] s, logic [7:0] i);
        logic [128:0] e;
        check_out();
        if (o inside {[1:2], [6:13]}) w = 1'b1; // these always write a vector register
        if (o == 14) w = 1'b0; // this one writes a media register
        e = model(o, w, m, a, d, s, i);
        exp_v = v;
        exp_f = v & e[128];
        exp_w = w;
        chk_w = v && (o inside {[1:16]});
        exp_r = v ? e[127:0] : '0;
        issue_model_inst.issue(v, 5'(o), w, m, a, d, s, i);
        @(negedge clk);
    endtask

    // valid, fault and result must read zero for the whole reset; wide is not checked
    task automatic do_reset();
        rst = 1'b1;
        {exp_v, exp_f, chk_w, exp_r} = '0;
        repeat (5) begin
            @(negedge clk);
            check_out();
        end
        rst = 1'b0;
    endtask

    task automatic print_verdict();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hung run still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        logic [63:0] a;
        void'($urandom(17306));
        do_reset();
        // every code, undefined codes included; both widths except codes 1, 2 and 6 to 14, whose width step fixes
        for (int o = 0; o < 32; o++) begin
            for (int w = 0; w < 2; w++) begin
                step(1, o, w[0], 0, 64'h0, rnd128(), rnd128(), 8'($urandom()));
            end
        end
        // every low address nibble, memory and register forms
        for (int k = 0; k < 16; k++) begin
            a = {$urandom(), $urandom()} & ~64'hf | 64'(k);
            step(1, 1, 1, 1, a, rnd128(), rnd128(), 8'h0);
            step(1, 1, 1, 0, a, rnd128(), rnd128(), 8'h0);
            step(1, 2, 1, 1, a, rnd128(), rnd128(), 8'h0);
        end
        // reset lands while a result is on the outputs
        step(1, 3, 1, 0, 64'h0, rnd128(), rnd128(), 8'h0);
        do_reset();
        // every immediate for the three shuffles
        for (int i = 0; i < 256; i++) begin
            for (int o = 6; o < 9; o++) step(1, o, 1, 0, 64'h0, rnd128(), rnd128(), 8'(i));
        end
        // byte counts across the zeroing boundary and the top code
        for (int i = 0; i < 22; i++) begin
            step(1, 9, 1, 0, 64'h0, rnd128(), rnd128(), (i == 21) ? 8'hff : 8'(i));
            step(1, 10, 1, 0, 64'h0, rnd128(), rnd128(), (i == 21) ? 8'hff : 8'(i));
        end
        // back-to-back random traffic with idle holes
        repeat (400) begin
            step(($urandom() % 4) != 0, $urandom() % 20, $urandom() % 2, $urandom() % 2,
                 ($urandom() % 2) ? {$urandom(), $urandom()} : 64'h40, rnd128(), rnd128(),
                 8'($urandom()));
        end
        step(0, 0, 0, 0, 64'h0, '0, '0, 8'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
